// ==== logic/srx_pkg.sv ====
package srx_pkg;
	// Register offsets; the bus address is the register index itself, data in lane 0
	localparam logic [7:0] OFS_RX_A_VALID   = 8'h0a;
	localparam logic [7:0] OFS_RX_B_DATA    = 8'h0b;
	localparam logic [7:0] OFS_RX_B_VALID   = 8'h0c;
	localparam logic [7:0] OFS_TX_IRQ_EN    = 8'h0d;
	localparam logic [7:0] OFS_TX_IRQ_FLAGS = 8'h0e;
	localparam logic [7:0] OFS_TX_DATA      = 8'h0f;
	localparam logic [7:0] OFS_RX_A_DATA    = 8'h09;
	// Transmit interrupt field positions
	localparam int BIT_EMPTY     = 0;
	localparam int BIT_DONE      = 1;
	localparam int BIT_OVERFLOW  = 2;
	localparam int BIT_UNDERFLOW = 3;
	localparam logic [7:0] TX_IRQ_WMASK = 8'h0f;
	localparam logic [7:0] RST_BYTE     = 8'h00;
	localparam logic [2:0] RST_COUNT    = 3'h0;
	// Clock cycles per shifted bit; sets the serialiser speed
	localparam int TX_BIT_CYCLES = 4;

	typedef struct packed {
		logic [7:0] data;
		logic [7:0] valid;
	} srx_byte_s;

	typedef struct packed {
		logic       bit_valid;
		logic       bit_data;
		logic       byte_end;
	} srx_rx_bit_s;
endpackage : srx_pkg

// ==== logic/srx_tx_ser.sv ====
`timescale 1ns/100ps
// Transmit serialiser: holding byte, shift register and flag events
module srx_tx_ser
	import srx_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic       load,
	input  wire logic [7:0] load_data,
	input  wire logic       tx_enable,
	output logic            tx_bit,
	output logic            tx_bit_valid,
	output logic            ev_empty,
	output logic            ev_done,
	output logic            ev_overflow,
	output logic            ev_underflow
);
	typedef struct packed {
		logic [7:0] hold;
		logic       hold_full;
		logic [7:0] shift;
		logic [2:0] bits_left;
		logic       busy;
		logic [7:0] tick;
		logic       tx_bit;
		logic       tx_bit_valid;
		logic       ev_empty;
		logic       ev_done;
		logic       ev_overflow;
		logic       ev_underflow;
	} srx_tx_s;

	srx_tx_s st;
	srx_tx_s next_st;

	// Shift LSB first; the holding byte moves to the shifter when it runs dry
	always_comb begin
		logic moving;
		moving = tx_enable && !st.busy && st.hold_full;
		next_st = st;
		next_st.ev_empty = 1'b0;
		next_st.ev_done = 1'b0;
		next_st.ev_overflow = 1'b0;
		next_st.ev_underflow = 1'b0;
		next_st.tx_bit_valid = 1'b0;
		if (load) begin
			// A byte leaving for the shifter in this cycle is not overwritten
			if (st.hold_full && !moving)
				next_st.ev_overflow = 1'b1;
			next_st.hold = load_data;       // Newest byte wins on overflow
			next_st.hold_full = 1'b1;
		end
		if (tx_enable && !st.busy) begin
			if (st.hold_full) begin
				next_st.shift = st.hold;
				next_st.busy = 1'b1;
				next_st.bits_left = 3'h7;
				next_st.tick = 8'h00;
				next_st.hold_full = load;
				next_st.ev_empty = 1'b1;
			end else if (!load) begin
				next_st.ev_underflow = 1'b1;
			end
		end else if (st.busy) begin
			if (st.tick == 8'(TX_BIT_CYCLES - 1)) begin
				next_st.tick = 8'h00;
				next_st.tx_bit = st.shift[0];
				next_st.tx_bit_valid = 1'b1;
				next_st.shift = {1'b0, st.shift[7:1]};
				next_st.bits_left = st.bits_left - 3'h1;
				if (st.bits_left == RST_COUNT) begin
					next_st.busy = 1'b0;
					if (!st.hold_full && !load)
						next_st.ev_done = 1'b1;
				end
			end else begin
				next_st.tick = st.tick + 8'h01;
			end
		end
	end

	// State register
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign tx_bit = st.tx_bit;
	assign tx_bit_valid = st.tx_bit_valid;
	assign ev_empty = st.ev_empty;
	assign ev_done = st.ev_done;
	assign ev_overflow = st.ev_overflow;
	assign ev_underflow = st.ev_underflow;
endmodule : srx_tx_ser

// ==== logic/srx_regs.sv ====
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/100ps
module srx_regs
	import srx_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        rx_a_bit,
	input  wire logic        rx_a_bit_valid,
	input  wire logic        rx_a_strobe,
	input  wire logic        rx_a_byte_end,
	input  wire logic        rx_b_bit,
	input  wire logic        rx_b_bit_valid,
	input  wire logic        rx_b_strobe,
	input  wire logic        rx_b_byte_end,
	input  wire logic        tx_enable,
	output logic             tx_bit,
	output logic             tx_bit_valid,
	output logic             rx_valid_data_a,
	output logic             rx_valid_data_b,
	output logic             irq
);
	typedef struct packed {
		srx_byte_s   asm_a;
		srx_byte_s   asm_b;
		logic [2:0]  pos_a;
		logic [2:0]  pos_b;
		srx_byte_s   out_a;
		srx_byte_s   out_b;
		logic        all_a;
		logic        all_b;
		logic [7:0]  irq_en;
		logic [7:0]  irq_flags;
		logic [31:0] rdata;
		logic        wait_n;
		logic        tx_load;
		logic [7:0]  tx_byte;
		logic        irq;
		logic [3:0]  sync1_a;
		logic [3:0]  sync2_a;
		logic [1:0]  prev_a;
		logic [3:0]  sync1_b;
		logic [3:0]  sync2_b;
		logic [1:0]  prev_b;
		logic [1:0]  sync_en;
	} srx_regs_s;

	srx_regs_s st;
	srx_regs_s next_st;
	logic      ev_empty;
	logic      ev_done;
	logic      ev_overflow;
	logic      ev_underflow;

	// Full address match; one byte register per address
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction : hit

	// Place one received bit at the current position, LSB first
	function automatic srx_byte_s put_bit(input srx_byte_s cur, input logic [2:0] pos,
		input logic b, input logic v);
		srx_byte_s r;
		r = cur;
		r.data[pos] = b;
		r.valid[pos] = v;
		put_bit = r;
	endfunction : put_bit

	srx_tx_ser u_tx (
		.clock        (clock),
		.reset_n      (reset_n),
		.load         (st.tx_load),
		.load_data    (st.tx_byte),
		.tx_enable    (st.sync_en[1]),
		.tx_bit       (tx_bit),
		.tx_bit_valid (tx_bit_valid),
		.ev_empty     (ev_empty),
		.ev_done      (ev_done),
		.ev_overflow  (ev_overflow),
		.ev_underflow (ev_underflow)
	);

	// Whole block state: sync, receive assembly, bus slave and interrupt flags
	always_comb begin
		logic [7:0] set;
		logic       rd_flags;
		logic       a_str;
		logic       b_str;
		logic       a_end;
		logic       b_end;
		set = 8'h00;
		rd_flags = 1'b0;
		next_st = st;
		// Two flops per pin, packed as strobe, frame end, valid, data
		next_st.sync1_a = {rx_a_strobe, rx_a_byte_end, rx_a_bit_valid, rx_a_bit};
		next_st.sync2_a = st.sync1_a;
		next_st.sync1_b = {rx_b_strobe, rx_b_byte_end, rx_b_bit_valid, rx_b_bit};
		next_st.sync2_b = st.sync1_b;
		next_st.sync_en = {st.sync_en[0], tx_enable};
		// Rising edges only, so a strobe held several clocks places one bit
		next_st.prev_a = st.sync2_a[3:2];
		next_st.prev_b = st.sync2_b[3:2];
		a_str = st.sync2_a[3] && !st.prev_a[1];
		a_end = st.sync2_a[2] && !st.prev_a[0];
		b_str = st.sync2_b[3] && !st.prev_b[1];
		b_end = st.sync2_b[2] && !st.prev_b[0];
		// Data and valid pass the same flops as the strobe, so they arrive together
		if (a_str) begin
			next_st.asm_a = put_bit(st.asm_a, st.pos_a, st.sync2_a[0], st.sync2_a[1]);
			next_st.pos_a = st.pos_a + 3'h1;
		end
		if (b_str) begin
			next_st.asm_b = put_bit(st.asm_b, st.pos_b, st.sync2_b[0], st.sync2_b[1]);
			next_st.pos_b = st.pos_b + 3'h1;
		end
		// A full byte or an early frame end moves the assembly to the host view
		if ((a_str && st.pos_a == 3'h7) || a_end) begin
			next_st.out_a = a_str ? next_st.asm_a : st.asm_a;
			next_st.all_a = &next_st.out_a.valid;
			next_st.asm_a = '0;
			next_st.pos_a = RST_COUNT;
		end
		if ((b_str && st.pos_b == 3'h7) || b_end) begin
			next_st.out_b = b_str ? next_st.asm_b : st.asm_b;
			next_st.all_b = &next_st.out_b.valid;
			next_st.asm_b = '0;
			next_st.pos_b = RST_COUNT;
		end
		// Avalon slave: one wait cycle, answer on the second edge
		next_st.tx_load = 1'b0;
		next_st.wait_n = 1'b0;
		if ((avs_read || avs_write) && !st.wait_n) begin
			next_st.wait_n = 1'b1;
			next_st.rdata = 32'h0000_0000;
			if (avs_read) begin
				if (hit(avs_address, OFS_RX_A_VALID))
					next_st.rdata[7:0] = st.out_a.valid;
				else if (hit(avs_address, OFS_RX_A_DATA))
					next_st.rdata[7:0] = st.out_a.data;
				else if (hit(avs_address, OFS_RX_B_DATA))
					next_st.rdata[7:0] = st.out_b.data;
				else if (hit(avs_address, OFS_RX_B_VALID))
					next_st.rdata[7:0] = st.out_b.valid;
				else if (hit(avs_address, OFS_TX_IRQ_EN))
					next_st.rdata[7:0] = st.irq_en;
				else if (hit(avs_address, OFS_TX_IRQ_FLAGS)) begin
					next_st.rdata[7:0] = st.irq_flags;
					rd_flags = 1'b1;
				end
			end
		end
		// A write lands at the edge that sees waitrequest low, never earlier
		if (avs_write && st.wait_n && avs_byteenable[0]) begin
			// Receive registers take no write
			if (hit(avs_address, OFS_TX_IRQ_EN))
				next_st.irq_en = avs_writedata[7:0] & TX_IRQ_WMASK;
			else if (hit(avs_address, OFS_TX_DATA)) begin
				next_st.tx_load = 1'b1;
				next_st.tx_byte = avs_writedata[7:0];
			end
		end
		// Events gated by their enables; set wins over the read clear
		set[BIT_UNDERFLOW] = ev_underflow && st.irq_en[BIT_UNDERFLOW];
		set[BIT_OVERFLOW] = ev_overflow && st.irq_en[BIT_OVERFLOW];
		set[BIT_DONE] = ev_done && st.irq_en[BIT_DONE];
		set[BIT_EMPTY] = ev_empty && st.irq_en[BIT_EMPTY];
		next_st.irq_flags = (rd_flags ? RST_BYTE : st.irq_flags) | set;
		next_st.irq = |(next_st.irq_flags & st.irq_en);
	end

	// State register
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign avs_readdata = st.rdata;
	assign avs_waitrequest = !st.wait_n;
	assign rx_valid_data_a = st.all_a;
	assign rx_valid_data_b = st.all_b;
	assign irq = st.irq;
endmodule : srx_regs

// ==== test/srx_regs_monitor.sv ====
`timescale 1ns/100ps
// Port checker for the register slice
module srx_regs_monitor
	import srx_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	input  wire logic        tx_bit_valid,
	input  wire logic        irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// Handshake steps: request taken, then a single low cycle
	sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
	sequence s_ans; !avs_waitrequest ##1 avs_waitrequest; endsequence
	property p_answer; s_req |=> s_ans; endproperty
	a_answer: assert property (p_answer) else $error("no answer");
	property p_cause; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
	a_cause: assert property (p_cause) else $error("stray answer");
	property p_idle; !(avs_read || avs_write) |=> avs_waitrequest; endproperty
	a_idle: assert property (p_idle) else $error("answer while idle");
	property p_upper; avs_readdata[31:8] == 24'h0; endproperty
	a_upper: assert property (p_upper) else $error("upper lanes set");
	property p_stand; !(avs_read || avs_write) |=> $stable(avs_readdata); endproperty
	a_stand: assert property (p_stand) else $error("read data moved");
	property p_resv; s_req ##0 (avs_read && avs_address == OFS_TX_IRQ_EN) |=> avs_readdata[7:4] == 4'h0; endproperty
	a_resv: assert property (p_resv) else $error("reserved enable bits");
	// An interrupt only drops after a flag read or an enable write
	property p_irqfall; $fell(irq) |-> $past(avs_read || avs_write) || $past(avs_read || avs_write, 2); endproperty
	a_irqfall: assert property (p_irqfall) else $error("irq dropped alone");
	property p_txbit; tx_bit_valid |=> !tx_bit_valid [*3]; endproperty
	a_txbit: assert property (p_txbit) else $error("bit spacing");
endmodule : srx_regs_monitor
bind srx_regs srx_regs_monitor u_mon (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .tx_bit_valid(tx_bit_valid), .irq(irq));

// ==== test/srx_rx_source.sv ====
`timescale 1ns/100ps
// Far-side receiver feeding one channel's bit pins
module srx_rx_source (
	input  wire logic clock,
	output logic      bit_out,
	output logic      bit_valid,
	output logic      strobe,
	output logic      byte_end
);
	initial begin
		bit_out = 1'b0;
		bit_valid = 1'b0;
		strobe = 1'b0;
		byte_end = 1'b0;
	end
	// Data settles before the strobe, phases of four clocks beat the synchroniser
	task automatic send(input logic [7:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clock);
			bit_out <= b[i];
			bit_valid <= 1'b1;
			repeat (2) @(posedge clock);
			strobe <= 1'b1;
			repeat (4) @(posedge clock);
			strobe <= 1'b0;
			repeat (4) @(posedge clock);
		end
		// Stale line shows the inverse so old data cannot pass
		bit_out <= ~b[n-1];
		bit_valid <= 1'b0;
		byte_end <= (n < 8);
		repeat (4) @(posedge clock);
		byte_end <= 1'b0;
		repeat (8) @(posedge clock);
	endtask : send
endmodule : srx_rx_source

// ==== test/srx_regs_bench.sv ====
`timescale 1ns/100ps
module srx_regs_bench
	import srx_pkg::*;
;
	logic        clock, reset_n, avs_read, avs_write, tx_enable, avs_waitrequest;
	logic        tx_bit, tx_bit_valid, rx_valid_data_a, rx_valid_data_b, irq;
	logic        ra_b, ra_v, ra_s, ra_e, rb_b, rb_v, rb_s, rb_e;
	logic [7:0]  avs_address, cap, q;
	logic [31:0] avs_writedata, avs_readdata;
	int          n_errors, samples_checked, cyc, n_tx;
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	srx_regs dut (.clock(clock), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_a_bit(ra_b),
		.rx_a_bit_valid(ra_v), .rx_a_strobe(ra_s), .rx_a_byte_end(ra_e), .rx_b_bit(rb_b),
		.rx_b_bit_valid(rb_v), .rx_b_strobe(rb_s), .rx_b_byte_end(rb_e), .tx_enable(tx_enable),
		.tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .rx_valid_data_a(rx_valid_data_a),
		.rx_valid_data_b(rx_valid_data_b), .irq(irq));
	srx_rx_source u_a (.clock(clock), .bit_out(ra_b), .bit_valid(ra_v), .strobe(ra_s), .byte_end(ra_e));
	srx_rx_source u_b (.clock(clock), .bit_out(rb_b), .bit_valid(rb_v), .strobe(rb_s), .byte_end(rb_e));
	task automatic give_verdict;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	// Serial capture, first bit ends in bit 0; also the hang guard
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (tx_bit_valid === 1'b1) begin
			cap <= {tx_bit, cap[7:1]};
			n_tx <= n_tx + 1;
		end
		if (cyc == 30000) begin
			n_errors++;
			give_verdict();
		end
	end
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %0t byte %h want %h", $time, g, e);
		end
	endtask : chk8
	task automatic chk1(input logic g, input logic e);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %0t flag %b want %b", $time, g, e);
		end
	endtask : chk1
	// One bus cycle, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_read <= !w;
		avs_write <= w;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk8(q, e);
	endtask : rd
	initial begin
		{reset_n, avs_read, avs_write, tx_enable, cyc, n_tx, n_errors, samples_checked} = '0;
		{avs_address, avs_writedata, cap} = '0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		for (int i = 11; i <= 14; i++)
			rd(8'(i), 8'h00);
		rd(8'h40, 8'h00);
		bus(1'b1, 8'h0b, 8'ha5);
		bus(1'b1, 8'h0c, 8'h5a);
		rd(8'h0b, 8'h00);
		rd(8'h0c, 8'h00);
		bus(1'b1, 8'h0d, 8'h0f);
		rd(8'h0d, 8'h0f);
		$display("test registers done");
		u_b.send(8'h96, 8);
		rd(8'h0b, 8'h96);
		rd(8'h0c, 8'hff);
		chk1(rx_valid_data_b, 1'b1);
		u_a.send(8'h0d, 5);
		rd(8'h0a, 8'h1f);
		chk1(rx_valid_data_a, 1'b0);
		$display("test receive done");
		bus(1'b1, 8'h0f, 8'h3c);
		tx_enable <= 1'b1;
		while (n_tx < 8) @(posedge clock);
		tx_enable <= 1'b0;
		repeat (2 * TX_BIT_CYCLES) @(posedge clock);
		chk8(cap, 8'h3c);
		chk1(irq, 1'b1);
		bus(1'b0, 8'h0e, 8'h00);
		chk8(q & 8'h03, 8'h03);
		rd(8'h0e, 8'h00);
		chk1(irq, 1'b0);
		bus(1'b1, 8'h0d, 8'h04);
		bus(1'b1, 8'h0f, 8'h11);
		bus(1'b1, 8'h0f, 8'h22);
		repeat (4) @(posedge clock);
		chk1(irq, 1'b1);
		bus(1'b0, 8'h0e, 8'h00);
		chk8(q & 8'h04, 8'h04);
		bus(1'b1, 8'h0d, 8'h00);
		tx_enable <= 1'b1;
		while (n_tx < 16) @(posedge clock);
		repeat (2 * TX_BIT_CYCLES) @(posedge clock);
		chk8(cap, 8'h22);
		chk1(irq, 1'b0);
		bus(1'b1, 8'h0d, 8'h08);
		repeat (4) @(posedge clock);
		chk1(irq, 1'b1);
		tx_enable <= 1'b0;
		repeat (8) @(posedge clock);
		bus(1'b0, 8'h0e, 8'h00);
		chk8(q & 8'h08, 8'h08);
		$display("test transmit done");
		give_verdict();
	end
endmodule : srx_regs_bench
